//--- pkg/rfas_pkg.sv
// Purpose: shared constants and types for the register field access block
// Assumes: one clock, asynchronous active-low reset
// Notes: field indices select one field of each access kind
package rfas_pkg;

    // ****************************************************
    // access kinds
    // ****************************************************
    typedef enum logic [2:0] {
        RFAS_RO   = 3'h0,
        RFAS_RW   = 3'h1,
        RFAS_RC   = 3'h2,
        RFAS_RWC  = 3'h3,
        RFAS_RW1C = 3'h4,
        RFAS_RW1S = 3'h5,
        RFAS_W1C  = 3'h6,
        RFAS_WO   = 3'h7
    } rfas_access_t;

    // ****************************************************
    // geometry and field indices
    // ****************************************************
    localparam int RFAS_WIDTH = 8;
    localparam int RFAS_IDX_W = 3;
    localparam logic [2:0] RFAS_IDX_RO = 3'h0;
    localparam logic [2:0] RFAS_IDX_RW = 3'h1;
    localparam logic [2:0] RFAS_IDX_RC = 3'h2;
    localparam logic [2:0] RFAS_IDX_RWC = 3'h3;
    localparam logic [2:0] RFAS_IDX_STATUS = 3'h4;
    localparam logic [2:0] RFAS_IDX_W1S = 3'h5;
    localparam logic [2:0] RFAS_IDX_W1C = 3'h6;
    localparam logic [2:0] RFAS_IDX_WO = 3'h7;

    // ****************************************************
    // values after reset
    // ****************************************************
    localparam logic [7:0] RFAS_RST_RW = 8'h00;
    localparam logic [7:0] RFAS_RST_RC = 8'h00;
    localparam logic [7:0] RFAS_RST_RWC = 8'h00;
    localparam logic [7:0] RFAS_RST_STATUS = 8'h00;
    localparam logic [7:0] RFAS_RST_W1S = 8'h00;
    localparam logic [7:0] RFAS_RST_WO = 8'h00;
    localparam logic [7:0] RFAS_RST_RO = 8'h00;
    localparam logic [7:0] RFAS_NO_DATA = 8'h00;

endpackage

//--- hw/rfas_field.sv
// Purpose: one register field of a chosen access kind
// Assumes: rd and wr are one-cycle strobes already decoded for this field
// Notes: hardware set always wins over a software clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module rfas_field #(
    parameter rfas_pkg::rfas_access_t ACC = rfas_pkg::RFAS_RW,
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // software access
    input wire logic rd,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    // hardware side
    input wire logic [W-1:0] hw_set,
    input wire logic [W-1:0] hw_val,
    input wire logic [W-1:0] ext_clr,
    // field state
    output logic [W-1:0] value,
    output logic [W-1:0] rdata
);

    logic [W-1:0] next_value;

    always_comb begin
        next_value = value;
        case (ACC)
            rfas_pkg::RFAS_RO: begin
                next_value = hw_val;
            end
            rfas_pkg::RFAS_RW, rfas_pkg::RFAS_WO: begin
                if (wr) begin
                    next_value = wdata; // [R9] [R7]
                end
            end
            rfas_pkg::RFAS_RC: begin
                // only a completed read clears
                if (rd) begin
                    next_value = '0; // [R1] [R12]
                end
                next_value = next_value | hw_set;
            end
            rfas_pkg::RFAS_RWC: begin
                if (wr) begin
                    next_value = '0; // [R2]
                end
                next_value = next_value | hw_set;
            end
            rfas_pkg::RFAS_RW1C: begin
                // ones clear, zeros keep; the partner write-only field clears too
                next_value = (value & ~((wr ? wdata : '0) | ext_clr)) | hw_set; // [R3] [R4]
            end
            rfas_pkg::RFAS_RW1S: begin
                if (wr) begin
                    next_value = value | wdata; // [R5]
                end
                next_value = next_value | hw_set;
            end
            rfas_pkg::RFAS_W1C: begin
                next_value = '0;
            end
            default: begin
                next_value = value;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            value <= RST; // [R10]
        end else begin
            value <= next_value;
        end
    end

    // write-only kinds answer a read with a fixed pattern, not stored data
    always_comb begin
        if (ACC == rfas_pkg::RFAS_WO || ACC == rfas_pkg::RFAS_W1C) begin
            rdata = rfas_pkg::RFAS_NO_DATA[W-1:0]; // [R6] [R7]
        end else begin
            rdata = value;
        end
    end

endmodule

`default_nettype wire

//--- hw/rfas_bank.sv
// Purpose: bank of eight fields, one of each access kind, behind a plain access port
// Assumes: access strobes come from logic on clk; event inputs are same-clock pulses
// Notes: read data is registered one cycle after the read strobe
//
// Functional notes
// R1 - clear-on-read field returns its value, then hardware clears it
// R2 - clear-on-write field clears on any write; reads have no side effect
// R3 - write-one-to-clear: ones clear matching bits, zeros and others keep
// R4 - writing back read status clears only bits set at read time
// R5 - write-one-to-set: ones set matching bits, zeros do nothing
// R6 - write-only one-to-clear clears interrupt bits; reads return nothing meaningful
// R7 - write-only field takes writes; reads return undefined data
// R8 - software writes read-only fields with their reset value
// R9 - read-write field stores the write and returns it on read
// R10 - every bit takes its reset value after any reset
// R11 - software ignores and preserves reserved bits
// R12 - read side effects happen only on a completed read access
`timescale 1ns/1ps
`default_nettype none

module rfas_bank #(
    parameter int W = rfas_pkg::RFAS_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // access port
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [rfas_pkg::RFAS_IDX_W-1:0] acc_index,
    input wire logic [W-1:0] acc_wdata,
    // hardware events and state
    input wire logic [W-1:0] hw_state,
    input wire logic [W-1:0] ev_count,
    input wire logic [W-1:0] ev_status,
    input wire logic [W-1:0] ev_flag,
    // read answer
    output logic [W-1:0] rd_data,
    output logic rd_valid,
    // field contents
    output logic [W-1:0] ctrl_value,
    output logic [W-1:0] wo_value,
    output logic [W-1:0] flag_value,
    output logic [W-1:0] status_value
);

    // ****************************************************
    // decode
    // ****************************************************
    function automatic logic hit(input logic [2:0] idx, input logic [2:0] fld);
        hit = (idx == fld);
    endfunction

    logic rd_any;
    logic wr_any;
    logic [W-1:0] rdata [8];
    logic [W-1:0] val [8];
    logic [W-1:0] zero;

    assign zero = '0;
    // a write never counts as a read, so it cannot trigger clear-on-read
    assign rd_any = acc_valid && !acc_write; // [R12]
    assign wr_any = acc_valid && acc_write;

    // ****************************************************
    // fields
    // ****************************************************
    // every field sees the shared write data; only its own strobes make it act, but a write-only clear write also clears the status field
    rfas_field #(
        .ACC(rfas_pkg::RFAS_RO),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_RO[W-1:0])
    ) u_ro (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_RO)),
        // writes are dropped here, so whatever software writes back is harmless
        .wr(1'b0), // [R8]
        .wdata(acc_wdata),
        .hw_set(zero),
        .hw_val(hw_state),
        .ext_clr(zero),
        .value(val[0]),
        .rdata(rdata[0])
    );

    rfas_field #(
        .ACC(rfas_pkg::RFAS_RW),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_RW[W-1:0])
    ) u_rw (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_RW)),
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_RW)), // [R9]
        .wdata(acc_wdata),
        .hw_set(zero),
        .hw_val(zero),
        .ext_clr(zero),
        .value(val[1]),
        .rdata(rdata[1])
    );

    // the write strobe reaches this field but has no effect on it
    rfas_field #(
        .ACC(rfas_pkg::RFAS_RC),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_RC[W-1:0])
    ) u_rc (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_RC)), // [R1]
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_RC)),
        .wdata(acc_wdata),
        .hw_set(ev_count),
        .hw_val(zero),
        .ext_clr(zero),
        .value(val[2]),
        .rdata(rdata[2])
    );

    rfas_field #(
        .ACC(rfas_pkg::RFAS_RWC),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_RWC[W-1:0])
    ) u_rwc (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_RWC)),
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_RWC)), // [R2]
        .wdata(acc_wdata),
        .hw_set(ev_count),
        .hw_val(zero),
        .ext_clr(zero),
        .value(val[3]),
        .rdata(rdata[3])
    );

    // the write-only clear field acts on this status field
    rfas_field #(
        .ACC(rfas_pkg::RFAS_RW1C),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_STATUS[W-1:0])
    ) u_status (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_STATUS)),
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_STATUS)), // [R3] [R4]
        .wdata(acc_wdata),
        .hw_set(ev_status),
        .hw_val(zero),
        .ext_clr((wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_W1C)) ? acc_wdata : zero), // [R6]
        .value(val[4]),
        .rdata(rdata[4])
    );

    rfas_field #(
        .ACC(rfas_pkg::RFAS_RW1S),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_W1S[W-1:0])
    ) u_w1s (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_W1S)),
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_W1S)), // [R5]
        .wdata(acc_wdata),
        .hw_set(ev_flag),
        .hw_val(zero),
        .ext_clr(zero),
        .value(val[5]),
        .rdata(rdata[5])
    );

    // holds nothing of its own; its writes land on the status field above
    rfas_field #(
        .ACC(rfas_pkg::RFAS_W1C),
        .W(W),
        .RST(rfas_pkg::RFAS_NO_DATA[W-1:0])
    ) u_w1c (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_W1C)),
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_W1C)),
        .wdata(acc_wdata),
        .hw_set(zero),
        .hw_val(zero),
        .ext_clr(zero),
        .value(val[6]),
        .rdata(rdata[6])
    );

    rfas_field #(
        .ACC(rfas_pkg::RFAS_WO),
        .W(W),
        .RST(rfas_pkg::RFAS_RST_WO[W-1:0])
    ) u_wo (
        .clk(clk),
        .nrst(nrst),
        .rd(rd_any && hit(acc_index, rfas_pkg::RFAS_IDX_WO)),
        .wr(wr_any && hit(acc_index, rfas_pkg::RFAS_IDX_WO)), // [R7]
        .wdata(acc_wdata),
        .hw_set(zero),
        .hw_val(zero),
        .ext_clr(zero),
        .value(val[7]),
        .rdata(rdata[7])
    );

    // ****************************************************
    // read answer
    // ****************************************************
    // sampled before the clear lands, so a clear-on-read returns the old value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= '0; // [R10]
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_any;
            if (rd_any) begin
                rd_data <= rdata[acc_index]; // [R1]
            end
        end
    end

    // field contents mirror flops inside the fields
    assign ctrl_value = val[1];
    assign status_value = val[4];
    assign flag_value = val[5];
    assign wo_value = val[7];

endmodule

`default_nettype wire

//--- verification/rfas_bank_checker.sv
// Purpose: port-level checks of the field bank
// Assumes: one access per cycle, read answer one cycle late
// Notes: event pulses feed the status and set fields
`timescale 1ns/1ps
`default_nettype none
module rfas_bank_checker #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // access and events
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [rfas_pkg::RFAS_IDX_W-1:0] acc_index,
    input wire logic [W-1:0] acc_wdata,
    input wire logic [W-1:0] ev_status,
    input wire logic [W-1:0] ev_flag,
    // outputs
    input wire logic [W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic [W-1:0] ctrl_value,
    input wire logic [W-1:0] wo_value,
    input wire logic [W-1:0] flag_value,
    input wire logic [W-1:0] status_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic rd;
    logic wr;
    logic [W-1:0] clr_mask;
    logic [W-1:0] set_mask;
    assign rd = acc_valid && !acc_write;
    assign wr = acc_valid && acc_write;
    // both clear paths land on the same status flops
    assign clr_mask = (wr && (acc_index == rfas_pkg::RFAS_IDX_STATUS ||
        acc_index == rfas_pkg::RFAS_IDX_W1C)) ? acc_wdata : '0;
    assign set_mask = (wr && acc_index == rfas_pkg::RFAS_IDX_W1S) ? acc_wdata : '0;
    property p_read_answer;
        rd |=> rd_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_rd_quiet;
        !rd |=> !rd_valid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
    property p_rw_store;
        wr && acc_index == rfas_pkg::RFAS_IDX_RW |=> ctrl_value == $past(acc_wdata);
    endproperty
    a_rw_store: assert property (p_rw_store) else $error("rw not stored");
    property p_rw_read;
        rd && acc_index == rfas_pkg::RFAS_IDX_RW |=> rd_data == $past(ctrl_value);
    endproperty
    a_rw_read: assert property (p_rw_read) else $error("rw read wrong");
    property p_status_next;
        1'b1 |=> status_value == (($past(status_value) & ~$past(clr_mask)) | $past(ev_status));
    endproperty
    a_status_next: assert property (p_status_next) else $error("status wrong");
    property p_w1c_clear;
        wr && acc_index == rfas_pkg::RFAS_IDX_W1C
            |=> (status_value & $past(acc_wdata) & ~$past(ev_status)) == '0;
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("w1c left bits");
    property p_flag_next;
        1'b1 |=> flag_value == ($past(flag_value) | $past(set_mask) | $past(ev_flag));
    endproperty
    a_flag_next: assert property (p_flag_next) else $error("set field wrong");
    property p_wo_store;
        wr && acc_index == rfas_pkg::RFAS_IDX_WO |=> wo_value == $past(acc_wdata);
    endproperty
    a_wo_store: assert property (p_wo_store) else $error("wo not stored");
    property p_wo_read;
        rd && acc_index[2:1] == 2'h3 |=> rd_data == rfas_pkg::RFAS_NO_DATA;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only read data");
endmodule
bind rfas_bank rfas_bank_checker #(.W(W)) u_chk (.clk, .nrst, .acc_valid, .acc_write,
    .acc_index, .acc_wdata, .ev_status, .ev_flag, .rd_data, .rd_valid, .ctrl_value,
    .wo_value, .flag_value, .status_value);
`default_nettype wire

//--- verification/test_register_field_access_semantics.sv
// Purpose: directed bench for the field bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: one idle cycle between accesses
`timescale 1ns/1ps
`default_nettype none
module test_register_field_access_semantics;
    logic clk, nrst, acc_valid, acc_write, rd_valid;
    logic [2:0] acc_index;
    logic [7:0] acc_wdata, hw_state, ev_count, ev_status, ev_flag, rd_data;
    logic [7:0] ctrl_value, wo_value, flag_value, status_value;
    int errors, n_compared;
    rfas_bank u_dut (.clk, .nrst, .acc_valid, .acc_write, .acc_index, .acc_wdata,
        .hw_state, .ev_count, .ev_status, .ev_flag, .rd_data, .rd_valid,
        .ctrl_value, .wo_value, .flag_value, .status_value);
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        {acc_valid, acc_write, acc_index, acc_wdata} = {2'h3, idx, d};
        step;
        acc_valid = 0;
        step;
    endtask
    // read waits a bounded time for the answer
    task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
        {acc_valid, acc_write, acc_index} = {2'h2, idx};
        step;
        acc_valid = 0;
        for (int i = 0; i < 4 && rd_valid !== 1'b1; i++) step;
        if (rd_valid !== 1'b1) begin
            errors++;
            $display("BAD t=%0t no read answer", $time);
            wrap_up;
        end
        chk(rd_data, exp);
        step;
    endtask
    task automatic ev(input logic [7:0] c, input logic [7:0] s, input logic [7:0] f);
        {ev_count, ev_status, ev_flag} = {c, s, f};
        step;
        {ev_count, ev_status, ev_flag} = 24'h000000;
    endtask
    task automatic t_reset;
        chk(ctrl_value | wo_value | flag_value | status_value, 8'h00);
        rd(rfas_pkg::RFAS_IDX_RC, rfas_pkg::RFAS_RST_RC);
        rd(rfas_pkg::RFAS_IDX_RWC, rfas_pkg::RFAS_RST_RWC);
        $display("done reset");
    endtask
    task automatic t_rw;
        wr(rfas_pkg::RFAS_IDX_RW, 8'hA5);
        chk(ctrl_value, 8'hA5);
        rd(rfas_pkg::RFAS_IDX_RW, 8'hA5);
        // software keeps the upper nibble it read and changes only the lower one
        wr(rfas_pkg::RFAS_IDX_RW, (8'hA5 & 8'hF0) | 8'h0C);
        rd(rfas_pkg::RFAS_IDX_RW, 8'hAC);
        $display("done rw");
    endtask
    task automatic t_clear;
        ev(8'h81, 8'h00, 8'h00);
        wr(rfas_pkg::RFAS_IDX_RC, 8'hFF);
        rd(rfas_pkg::RFAS_IDX_RC, 8'h81);
        rd(rfas_pkg::RFAS_IDX_RC, 8'h00);
        rd(rfas_pkg::RFAS_IDX_RWC, 8'h81);
        wr(rfas_pkg::RFAS_IDX_RWC, 8'h00);
        rd(rfas_pkg::RFAS_IDX_RWC, 8'h00);
        $display("done clear");
    endtask
    task automatic t_status;
        ev(8'h00, 8'h36, 8'h00);
        rd(rfas_pkg::RFAS_IDX_STATUS, 8'h36);
        ev(8'h00, 8'h40, 8'h00);
        wr(rfas_pkg::RFAS_IDX_STATUS, 8'h36);
        chk(status_value, 8'h40);
        wr(rfas_pkg::RFAS_IDX_STATUS, 8'h00);
        chk(status_value, 8'h40);
        wr(rfas_pkg::RFAS_IDX_W1C, 8'h40);
        chk(status_value, 8'h00);
        rd(rfas_pkg::RFAS_IDX_W1C, rfas_pkg::RFAS_NO_DATA);
        $display("done status");
    endtask
    task automatic t_set_wo;
        wr(rfas_pkg::RFAS_IDX_W1S, 8'h11);
        wr(rfas_pkg::RFAS_IDX_W1S, 8'h00);
        ev(8'h00, 8'h00, 8'h80);
        wr(rfas_pkg::RFAS_IDX_W1S, 8'h02);
        rd(rfas_pkg::RFAS_IDX_W1S, 8'h93);
        wr(rfas_pkg::RFAS_IDX_WO, 8'hC3);
        chk(wo_value, 8'hC3);
        rd(rfas_pkg::RFAS_IDX_WO, rfas_pkg::RFAS_NO_DATA);
        hw_state = 8'h6B;
        wr(rfas_pkg::RFAS_IDX_RO, rfas_pkg::RFAS_RST_RO);
        rd(rfas_pkg::RFAS_IDX_RO, 8'h6B);
        $display("done set and write-only");
    endtask
    task automatic t_rereset;
        // leave status bits set so the reset has something to clear
        ev(8'h00, 8'h0C, 8'h00);
        chk(status_value, 8'h0C);
        nrst = 0;
        step;
        nrst = 1;
        step;
        chk(ctrl_value | wo_value | flag_value | status_value, 8'h00);
        $display("done second reset");
    endtask
    initial begin
        {nrst, acc_valid, acc_write, acc_index, acc_wdata} = 14'h0000;
        {hw_state, ev_count, ev_status, ev_flag} = 32'h00000000;
        errors = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        #1 nrst = 1;
        step;
        t_reset;
        t_rw;
        t_clear;
        t_status;
        t_set_wo;
        t_rereset;
        wrap_up;
    end
endmodule
`default_nettype wire
